// File: rtl/measurement_control_status.sv
// Notes on behaviour
// - writing one to the reset bit resets the block; reads give zero
// - diagnostic field: 00 off, 01 plus offset, 10 minus, 11 reserved
// - writing one to the run bit starts a conversion
// - run bit reads one while converting, zero when idle
// - single mode clears the run bit when the conversion ends
// - continuous mode: writing zero stops and returns to idle
// - with measurement off, analog power follows the block power setting
// - source field: 00 temperature, 01 amplifier, 10 auxiliary, 11 reserved
// - repeat bit: zero single conversion, one continuous
// - boot flag is one from start of eeprom load until it completes
// - clock flag reads one while the system clock runs
// - new result data clears the not-ready flag
// - reading a result high byte sets the not-ready flag
// - sensitivity overflow sets saturation flag and forces 7fff or 8000 into amplifier and auxiliary results, not temperature
// - coefficient overflow sets the coefficient error flag
// - offset overflow sets the offset error flag
// - reading a result high byte clears the three error flags
// - amplifier result is signed 16 bits at 0x02 high, 0x03 low
// - temperature is 10 bits: byte 0x06 plus top two bits of 0x07
`timescale 1ns/1ps
module measurement_control_status
  import conversion_run_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire reg_req_t reg_req,
  input wire result_t result_in,
  input wire logic boot_done,
  input wire logic sys_clk_running,
  input wire logic [7:0] block_power_setting,
  input wire logic [7:0] seq_power,
  output logic [7:0] reg_rdata_q,
  output logic conv_start_q,
  output logic conv_stop_q,
  output logic sw_reset_q,
  output diag_offset_t sensor_diag_offset_q,
  output input_source_t input_source_select_q,
  output logic repeat_select_q,
  output logic conversion_run_q,
  output logic [7:0] analog_power_q
);

  ////////////////////////////////////////////////////////////////////////
  // decode

  logic wr_ctrl;
  logic soft_rst;
  logic rd_high;
  logic [7:0] ctrl_view;
  logic [7:0] stat_view;

  function automatic logic is_high_byte(input logic [7:0] a);
    return (a == ADDR_AMP_HI) || (a == ADDR_AUX_HI) || (a == ADDR_TMP_HI);
  endfunction : is_high_byte

  assign wr_ctrl = reg_req.wr && (reg_req.addr == ADDR_CTRL);
  assign soft_rst = wr_ctrl && reg_req.wdata[CTRL_RST_BIT];
  assign rd_high = reg_req.rd && is_high_byte(reg_req.addr);

  ////////////////////////////////////////////////////////////////////////
  // clock activity synchroniser

  logic clk_meta_q;
  logic clk_run_q;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      clk_meta_q <= 1'b0;
      clk_run_q <= 1'b0;
    end else begin
      clk_meta_q <= sys_clk_running;
      clk_run_q <= clk_meta_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // control fields

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      sensor_diag_offset_q <= DIAG_OFF;
      input_source_select_q <= SRC_TEMP;
      repeat_select_q <= REP_RESET;
    end else if (soft_rst) begin
      sensor_diag_offset_q <= DIAG_OFF;
      input_source_select_q <= SRC_TEMP;
      repeat_select_q <= REP_RESET;
    end else if (wr_ctrl) begin
      sensor_diag_offset_q <=
        diag_offset_t'(reg_req.wdata[CTRL_DIAG_LSB +: 2]);
      input_source_select_q <=
        input_source_t'(reg_req.wdata[CTRL_SRC_LSB +: 2]);
      repeat_select_q <= reg_req.wdata[CTRL_REP_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // conversion run control

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      conversion_run_q <= 1'b0;
      conv_start_q <= 1'b0;
      conv_stop_q <= 1'b0;
    end else begin
      conv_start_q <= 1'b0;
      conv_stop_q <= 1'b0;
      if (soft_rst) begin
        conversion_run_q <= 1'b0;
        conv_stop_q <= conversion_run_q;
      end else if (wr_ctrl && reg_req.wdata[CTRL_RUN_BIT]) begin
        conversion_run_q <= 1'b1;
        conv_start_q <= 1'b1;
      end else if (wr_ctrl && conversion_run_q && repeat_select_q) begin
        conversion_run_q <= 1'b0;
        conv_stop_q <= 1'b1;
      end else if (conversion_run_q && !repeat_select_q &&
                   result_in.valid) begin
        conversion_run_q <= 1'b0;
      end
    end
  end

  // analog power source selection
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      analog_power_q <= 8'h00;
    end else begin
      analog_power_q <= conversion_run_q ? seq_power
                                         : block_power_setting;
    end
  end

  // software reset pulse to the rest of the chip
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      sw_reset_q <= 1'b0;
    end else begin
      sw_reset_q <= soft_rst;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // status flags

  logic boot_q;
  logic not_ready_q;
  logic sat_q;
  logic coef_q;
  logic ofs_q;
  logic sat_evt;

  assign sat_evt = result_in.valid &&
                   (result_in.sat_pos || result_in.sat_neg);

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      boot_q <= BOOT_RESET;
    end else if (soft_rst) begin
      boot_q <= BOOT_RESET;
    end else if (boot_done) begin
      boot_q <= 1'b0;
    end
  end

  // new data wins over a simultaneous high byte read
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      not_ready_q <= RDY_RESET;
    end else if (soft_rst) begin
      not_ready_q <= RDY_RESET;
    end else if (result_in.valid) begin
      not_ready_q <= 1'b0;
    end else if (rd_high) begin
      not_ready_q <= 1'b1;
    end
  end

  // set wins over read clear
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      sat_q <= 1'b0;
      coef_q <= 1'b0;
      ofs_q <= 1'b0;
    end else if (soft_rst) begin
      sat_q <= 1'b0;
      coef_q <= 1'b0;
      ofs_q <= 1'b0;
    end else begin
      sat_q <= sat_evt || (sat_q && !rd_high);
      coef_q <= (result_in.valid && result_in.coef_ovf) ||
                (coef_q && !rd_high);
      ofs_q <= (result_in.valid && result_in.offset_ovf) ||
               (ofs_q && !rd_high);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // result registers

  logic [15:0] amp_q;
  logic [15:0] aux_q;
  logic [9:0] temp_q;
  logic [15:0] forced;

  always_comb begin
    forced = result_in.value;
    if (result_in.sat_pos) begin
      forced = SAT_POS_VALUE;
    end else if (result_in.sat_neg) begin
      forced = SAT_NEG_VALUE;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      amp_q <= RESULT_RESET;
      aux_q <= RESULT_RESET;
    end else if (soft_rst) begin
      amp_q <= RESULT_RESET;
      aux_q <= RESULT_RESET;
    end else if (result_in.valid) begin
      if (result_in.source == SRC_AMP) begin
        amp_q <= forced;
      end
      if (result_in.source == SRC_AUX) begin
        aux_q <= forced;
      end
    end
  end

  // temperature is also host writable for external sensor values
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      temp_q <= TEMP_RESET;
    end else if (soft_rst) begin
      temp_q <= TEMP_RESET;
    end else if (result_in.valid && result_in.source == SRC_TEMP) begin
      temp_q <= result_in.value[9:0];
    end else if (reg_req.wr && reg_req.addr == ADDR_TMP_HI) begin
      temp_q <= {reg_req.wdata, temp_q[1:0]};
    end else if (reg_req.wr && reg_req.addr == ADDR_TMP_LO) begin
      temp_q <= {temp_q[9:2], reg_req.wdata[7:6]};
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read path

  always_comb begin
    ctrl_view = 8'h00; // reset bit and bit 7 read zero
    ctrl_view[CTRL_DIAG_LSB +: 2] = sensor_diag_offset_q;
    ctrl_view[CTRL_RUN_BIT] = conversion_run_q;
    ctrl_view[CTRL_SRC_LSB +: 2] = input_source_select_q;
    ctrl_view[CTRL_REP_BIT] = repeat_select_q;
    stat_view = 8'h00;
    stat_view[STAT_BOOT_BIT] = boot_q;
    stat_view[STAT_CLK_BIT] = clk_run_q;
    stat_view[STAT_RDY_BIT] = not_ready_q;
    stat_view[STAT_SAT_BIT] = sat_q;
    stat_view[STAT_COEF_BIT] = coef_q;
    stat_view[STAT_OFS_BIT] = ofs_q;
  end

  // status has no write path at all
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata_q <= 8'h00;
    end else if (reg_req.rd) begin
      unique case (reg_req.addr)
        ADDR_CTRL: reg_rdata_q <= ctrl_view;
        ADDR_STATUS: reg_rdata_q <= stat_view;
        ADDR_AMP_HI: reg_rdata_q <= amp_q[15:8];
        ADDR_AMP_LO: reg_rdata_q <= amp_q[7:0];
        ADDR_AUX_HI: reg_rdata_q <= aux_q[15:8];
        ADDR_AUX_LO: reg_rdata_q <= aux_q[7:0];
        ADDR_TMP_HI: reg_rdata_q <= temp_q[9:2];
        ADDR_TMP_LO: reg_rdata_q <= {temp_q[1:0], 6'h00};
        default: reg_rdata_q <= 8'h00;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // assertions

  soft_reset_a: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    soft_rst |=> sw_reset_q && !conversion_run_q && boot_q)
    else $error("soft reset did not take effect");

  run_start_a: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    wr_ctrl && reg_req.wdata[CTRL_RUN_BIT] && !soft_rst
    |=> conversion_run_q && conv_start_q)
    else $error("conversion did not start");

  run_read_a: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    reg_req.rd && reg_req.addr == ADDR_CTRL
    |=> reg_rdata_q[CTRL_RUN_BIT] == $past(conversion_run_q)
        && !reg_rdata_q[CTRL_RST_BIT])
    else $error("run bit read wrong");

  single_done_a: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    conversion_run_q && !repeat_select_q && result_in.valid && !wr_ctrl
    |=> !conversion_run_q)
    else $error("single conversion did not stop");

  cont_stop_a: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    conversion_run_q && repeat_select_q && wr_ctrl &&
    reg_req.wdata[7:6] == 2'b00 && !reg_req.wdata[CTRL_RUN_BIT]
    |=> !conversion_run_q && conv_stop_q)
    else $error("continuous conversion did not stop");

  power_follow_a: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    !conversion_run_q |=> analog_power_q == $past(block_power_setting))
    else $error("analog power ignores block setting");

  rdy_cycle_a: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    result_in.valid && !soft_rst |=> !not_ready_q)
    else $error("not ready flag sequence wrong");

  sat_force_a: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    result_in.valid && result_in.source == SRC_AMP &&
    result_in.sat_pos && !soft_rst
    |=> amp_q == SAT_POS_VALUE && sat_q && !not_ready_q)
    else $error("positive saturation not forced");

  err_clear_a: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    rd_high && !result_in.valid && !soft_rst
    |=> !sat_q && !coef_q && !ofs_q && not_ready_q)
    else $error("error flags not cleared by read");

  boot_done_a: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    boot_done && !soft_rst
    |=> !boot_q ##1 ($past(soft_rst) || !boot_q))
    else $error("boot flag did not clear");

endmodule : measurement_control_status

// File: shared/conversion_run_pkg.sv
package conversion_run_pkg;
  // register map
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h01;
  localparam logic [7:0] ADDR_AMP_HI = 8'h02;
  localparam logic [7:0] ADDR_AMP_LO = 8'h03;
  localparam logic [7:0] ADDR_AUX_HI = 8'h04;
  localparam logic [7:0] ADDR_AUX_LO = 8'h05;
  localparam logic [7:0] ADDR_TMP_HI = 8'h06;
  localparam logic [7:0] ADDR_TMP_LO = 8'h07;
  // control fields
  localparam int CTRL_RST_BIT = 6;
  localparam int CTRL_DIAG_LSB = 4;
  localparam int CTRL_RUN_BIT = 3;
  localparam int CTRL_SRC_LSB = 1;
  localparam int CTRL_REP_BIT = 0;
  // status fields
  localparam int STAT_BOOT_BIT = 5;
  localparam int STAT_CLK_BIT = 4;
  localparam int STAT_RDY_BIT = 3;
  localparam int STAT_SAT_BIT = 2;
  localparam int STAT_COEF_BIT = 1;
  localparam int STAT_OFS_BIT = 0;
  // reset values
  localparam logic [1:0] DIAG_RESET = 2'h0;
  localparam logic [1:0] SRC_RESET = 2'h0;
  localparam logic REP_RESET = 1'b0;
  localparam logic BOOT_RESET = 1'b1;
  localparam logic RDY_RESET = 1'b1;
  localparam logic [15:0] RESULT_RESET = 16'h0000;
  localparam logic [9:0] TEMP_RESET = 10'h000;
  // saturation values
  localparam logic [15:0] SAT_POS_VALUE = 16'h7FFF;
  localparam logic [15:0] SAT_NEG_VALUE = 16'h8000;

  typedef enum logic [1:0] {
    DIAG_OFF = 2'b00,
    DIAG_PLUS = 2'b01,
    DIAG_MINUS = 2'b10,
    DIAG_RSVD = 2'b11
  } diag_offset_t;

  typedef enum logic [1:0] {
    SRC_TEMP = 2'b00,
    SRC_AMP = 2'b01,
    SRC_AUX = 2'b10,
    SRC_RSVD = 2'b11
  } input_source_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic valid;
    logic [1:0] source;
    logic [15:0] value;
    logic sat_pos;
    logic sat_neg;
    logic coef_ovf;
    logic offset_ovf;
  } result_t;
endpackage : conversion_run_pkg

// File: verification/conv_model.sv
`timescale 1ns/1ps
module conv_model
  import conversion_run_pkg::*;
#(
  parameter int DELAY = 6
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic start,
  input wire logic stop,
  input wire logic repeat_on,
  input wire logic [1:0] source,
  input wire logic [19:0] payload,
  output result_t result_out
);
  int count_q = 0;
  logic busy_q = 1'b0;
  logic done;
  assign done = busy_q && (count_q == 0);
  ////////////////////////////////////////////////////////////////////////////
  // conversion timer, reloads itself in continuous mode
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b || stop) begin
      busy_q <= 1'b0;
    end else if (start || (done && repeat_on)) begin
      busy_q <= 1'b1;
      count_q <= DELAY;
    end else if (done) begin
      busy_q <= 1'b0;
    end else if (busy_q) begin
      count_q <= count_q - 1;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // idle lines carry the inverse pattern
  always_comb begin
    if (done) begin
      result_out = {1'b1, source, payload[15:0], payload[19:16]};
    end else begin
      result_out = {1'b0, ~source, ~payload[15:0], ~payload[19:16]};
    end
  end
endmodule : conv_model

// File: verification/test_measurement_control_status.sv
`timescale 1ns/1ps
module test_measurement_control_status;
  import conversion_run_pkg::*;
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  reg_req_t reg_req = '0;
  result_t result_in;
  logic boot_done = 1'b0;
  logic sys_clk_running = 1'b1;
  logic [19:0] payload = '0;
  logic [7:0] rdata;
  logic saw_rst = 1'b0;
  logic saw_stop = 1'b0;
  logic saw_start = 1'b0;
  logic [7:0] block_power = 8'hA5;
  int failures = 0;
  int checks_done = 0;
  int cycles = 0;
  logic [7:0] reg_rdata_q, analog_power_q;
  logic conv_start_q, conv_stop_q, sw_reset_q;
  logic repeat_select_q, conversion_run_q;
  diag_offset_t sensor_diag_offset_q;
  input_source_t input_source_select_q;
  always #25 sys_clk = ~sys_clk;
  ////////////////////////////////////////////////////////////////////////////
  measurement_control_status DUT (
    .sys_clk, .rst_b, .reg_req, .result_in, .boot_done, .sys_clk_running,
    .block_power_setting(block_power), .seq_power(8'h5A), .reg_rdata_q,
    .conv_start_q, .conv_stop_q, .sw_reset_q, .sensor_diag_offset_q,
    .input_source_select_q, .repeat_select_q, .conversion_run_q,
    .analog_power_q
  );
  conv_model #(.DELAY(6)) MODEL (
    .sys_clk, .rst_b, .start(conv_start_q), .stop(conv_stop_q),
    .repeat_on(repeat_select_q), .source(input_source_select_q),
    .payload(payload), .result_out(result_in)
  );
  ////////////////////////////////////////////////////////////////////////////
  task automatic stop_test();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : stop_test
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(negedge sys_clk);
    reg_req = '0;
    @(negedge sys_clk);
  endtask : wr
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    reg_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(negedge sys_clk);
    reg_req = '0;
    rdata = reg_rdata_q;
    check(rdata, exp);
    @(negedge sys_clk);
  endtask : rd_chk
  task automatic wait_idle();
    for (int k = 0; k < 40 && conversion_run_q !== 1'b0; k++) begin
      @(negedge sys_clk);
    end
    check({7'h0, conversion_run_q}, 8'h00);
  endtask : wait_idle
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_boot();
    repeat (3) @(negedge sys_clk);
    rd_chk(ADDR_CTRL, 8'h00);
    rd_chk(ADDR_STATUS, 8'h38);
    wr(ADDR_STATUS, 8'h00);
    rd_chk(ADDR_STATUS, 8'h38);
    boot_done = 1'b1;
    @(negedge sys_clk);
    boot_done = 1'b0;
    rd_chk(ADDR_STATUS, 8'h18);
    sys_clk_running = 1'b0;
    repeat (4) @(negedge sys_clk);
    rd_chk(ADDR_STATUS, 8'h08);
    sys_clk_running = 1'b1;
    repeat (4) @(negedge sys_clk);
    rd_chk(ADDR_STATUS, 8'h18);
    $display("test boot done");
  endtask : t_boot
  task automatic t_fields();
    logic [7:0] v;
    for (int i = 0; i < 4; i++) begin
      for (int j = 0; j < 4; j++) begin
        v = {2'b00, 2'(i), 1'b0, 2'(j), 1'(j)};
        wr(ADDR_CTRL, v);
        rd_chk(ADDR_CTRL, v);
        check({6'h0, sensor_diag_offset_q}, 8'(i));
        check({6'h0, input_source_select_q}, 8'(j));
        check({7'h0, repeat_select_q}, 8'(j % 2));
      end
    end
    wr(ADDR_CTRL, 8'h00);
    $display("test fields done");
  endtask : t_fields
  task automatic t_single();
    payload = 20'h8_1234;
    wr(ADDR_CTRL, 8'h0A);
    check({7'h0, conversion_run_q}, 8'h01);
    check({7'h0, saw_start}, 8'h01);
    rd_chk(ADDR_CTRL, 8'h0A);
    wait_idle();
    rd_chk(ADDR_STATUS, 8'h14);
    rd_chk(ADDR_AMP_HI, 8'h7F);
    rd_chk(ADDR_AMP_LO, 8'hFF);
    rd_chk(ADDR_STATUS, 8'h18);
    payload = 20'h7_1234;
    wr(ADDR_CTRL, 8'h0C);
    wait_idle();
    rd_chk(ADDR_STATUS, 8'h17);
    rd_chk(ADDR_AUX_HI, 8'h80);
    rd_chk(ADDR_AUX_LO, 8'h00);
    rd_chk(ADDR_STATUS, 8'h18);
    $display("test single done");
  endtask : t_single
  task automatic t_cont();
    payload = 20'h0_0155;
    wr(ADDR_CTRL, 8'h09);
    repeat (30) @(negedge sys_clk);
    check({7'h0, conversion_run_q}, 8'h01);
    check(analog_power_q, 8'h5A);
    rd_chk(ADDR_TMP_HI, 8'h55);
    rd_chk(ADDR_TMP_LO, 8'h40);
    wr(ADDR_CTRL, 8'h01);
    check({7'h0, conversion_run_q}, 8'h00);
    check({7'h0, saw_stop}, 8'h01);
    repeat (2) @(negedge sys_clk);
    check(analog_power_q, 8'hA5);
    block_power = 8'h3C;
    repeat (2) @(negedge sys_clk);
    check(analog_power_q, 8'h3C);
    $display("test continuous done");
  endtask : t_cont
  task automatic t_swreset();
    wr(ADDR_TMP_HI, 8'hAB);
    wr(ADDR_TMP_LO, 8'hC0);
    rd_chk(ADDR_TMP_HI, 8'hAB);
    rd_chk(ADDR_TMP_LO, 8'hC0);
    wr(ADDR_CTRL, 8'h35);
    rd_chk(ADDR_CTRL, 8'h35);
    wr(ADDR_CTRL, 8'h48);
    rd_chk(ADDR_CTRL, 8'h00);
    check({7'h0, saw_rst}, 8'h01);
    rd_chk(ADDR_STATUS, 8'h38);
    rd_chk(ADDR_TMP_HI, 8'h00);
    $display("test soft reset done");
  endtask : t_swreset
  ////////////////////////////////////////////////////////////////////////////
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (sw_reset_q === 1'b1) saw_rst <= 1'b1;
    if (conv_stop_q === 1'b1) saw_stop <= 1'b1;
    if (conv_start_q === 1'b1) saw_start <= 1'b1;
    if (cycles == 3000) begin
      failures++;
      stop_test();
    end
  end
  initial begin
    repeat (4) @(negedge sys_clk);
    rst_b = 1'b1;
    @(negedge sys_clk);
    t_boot();
    t_fields();
    t_single();
    t_cont();
    t_swreset();
    stop_test();
  end
endmodule : test_measurement_control_status
